// File: design/dsrc_pkg.sv
// Package: register map, reset values, field positions and carrier types of the control bank
package dsrc_pkg;

    // Register offsets
    localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
    localparam logic [7:0] OFS_SOFT_RST = 8'h01;
    localparam logic [7:0] OFS_OUT_CFG = 8'h02;
    localparam logic [7:0] OFS_GEN_CFG_B = 8'h03;

    // Reset values
    localparam logic [7:0] RST_SOFT_RST = 8'h04;
    localparam logic [7:0] RST_OUT_CFG = 8'h80;
    localparam logic [7:0] RST_GEN_CFG_B = 8'hf0;
    localparam logic RST_ADDR_SRC_SEL = 1'h0;

    // Field positions
    localparam int ADDR_SRC_SEL_BIT = 0;
    localparam int FULL_RST_BIT = 1;
    localparam int LOGIC_RST_BIT = 0;
    localparam int OE_VALUE_BIT = 7;
    localparam int OE_OVERRIDE_BIT = 6;
    localparam int FALLBACK_CLK_BIT = 5;
    localparam int SLEEP_STATE_BIT = 4;

    // Cycles a soft reset request stays asserted before its bit clears
    localparam int SOFT_RST_HOLD = 4;

    // Serial target states, Gray along the write path; ST_ACK to ST_READ flips two bits
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ACK = 3'h3,
        ST_WRITE = 3'h2,
        ST_READ = 3'h6,
        ST_RACK = 3'h7
    } dsrc_state_t;

    // Internal register write strobe with its data
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } dsrc_write_t;

    // Controls handed to the rest of the deserializer core
    typedef struct packed {
        logic outputEnable;
        logic sleepStateSel;
        logic oscClockToPclk;
        logic fullCoreReset;
        logic logicReset;
        logic [6:0] ownAddress;
        logic [7:0] genCfgB;
    } dsrc_ctrl_t;

endpackage

// File: design/dsrc_ctrl_regs.sv
// Control register bank with its serial-bus target, address select and soft resets
//
// Operation
// R01: Address bits 7-1 hold own address, strap-loaded.
// R02: Bit 0 picks strap or programmed address.
// R03: Reset bit 1 resets core and registers.
// R04: Full reset reloads address from latched strap.
// R05: Reset bit 0 resets core, keeps registers.
// R06: Reset register comes up as 04h.
// R07: Output enable value bit 7, default 1.
// R08: Host issues logic reset after enable rises.
// R09: Bit 6 makes programmed enable and sleep apply.
// R10: Bit 5 plus lost lock: oscillator to pixel clock.
// R11: Bit 4 is sleep select; default 1.
// R12: Output config resets zero-ish, low bits RW.
// R13: Self-clearing bits read 0 when done.
`timescale 1ns/1ps
`default_nettype none

module dsrc_ctrl_regs #(
    parameter int RST_HOLD = dsrc_pkg::SOFT_RST_HOLD
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [6:0] addressStrap,
    input wire logic lockPin,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output dsrc_pkg::dsrc_ctrl_t ctrl
);
    import dsrc_pkg::*;

    // Pin synchronisers: scl, sda, lock
    logic [2:0] sync1_q, sync2_q, sync3_q, filt_q, prev_q;
    logic [2:0] filt_d;
    logic sclF, sdaF, lockF, sclPrev, sdaPrev;
    logic sclRise, sclFall, startSeen, stopSeen;

    // Serial target state
    dsrc_state_t st_q, st_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
    logic rw_q, rw_d, first_q, first_d, drv_q, drv_d;
    dsrc_write_t wr;

    // Register bank state
    logic [7:0] addrReg_q, addrReg_d, rstReg_q, rstReg_d, cfg_q, cfg_d, cfgB_q, cfgB_d;
    logic [6:0] strapLatch_q, strapLatch_d;
    logic strapTaken_q, strapTaken_d;
    logic [7:0] holdCnt_q, holdCnt_d;
    logic [6:0] myAddr;
    logic [7:0] rdData;

    // A level counts once the second and third stage agree
    always_comb
    begin
        filt_d = (~(sync2_q ^ sync3_q) & sync2_q) | ((sync2_q ^ sync3_q) & filt_q);
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
            sync3_q <= 3'h7;
            filt_q <= 3'h7;
            prev_q <= 3'h7;
        end
        else
        begin
            sync1_q <= {lockPin, sdaIn, sclIn};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q <= filt_d;
            prev_q <= filt_q;
        end
    end

    // Bus events from the filtered levels
    assign sclF = filt_q[0];
    assign sdaF = filt_q[1];
    assign lockF = filt_q[2];
    assign sclPrev = prev_q[0];
    assign sdaPrev = prev_q[1];
    assign sclRise = sclF & ~sclPrev;
    assign sclFall = ~sclF & sclPrev;
    assign startSeen = sclF & sclPrev & sdaPrev & ~sdaF;
    assign stopSeen = sclF & sclPrev & ~sdaPrev & sdaF;

    // Answering address: strap or programmed field
    assign myAddr = addrReg_q[ADDR_SRC_SEL_BIT] ? addrReg_q[7:1] : strapLatch_q; // [R02]

    // Read mux; self-clearing bits show live state so the host can poll
    always_comb
    begin
        case (ptr_q)
            OFS_OWN_ADDR: rdData = addrReg_q;
            OFS_SOFT_RST: rdData = rstReg_q; // [R13]
            OFS_OUT_CFG: rdData = cfg_q;
            OFS_GEN_CFG_B: rdData = cfgB_q;
            default: rdData = 8'h00;
        endcase
    end

    // Serial target next state; first written byte sets the pointer
    always_comb
    begin
        st_d = st_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        first_d = first_q;
        drv_d = drv_q;
        wr.en = 1'b0;
        wr.addr = ptr_q;
        wr.data = shift_q;
        if (startSeen)
        begin
            st_d = ST_ADDR;
            bitCnt_d = 4'h0;
            first_d = 1'b1;
            drv_d = 1'b0;
        end
        else if (stopSeen)
        begin
            st_d = ST_IDLE;
            drv_d = 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    drv_d = 1'b0;
                end
                ST_ADDR, ST_WRITE:
                begin
                    if (sclRise)
                    begin
                        shift_d = {shift_q[6:0], sdaF};
                        bitCnt_d = bitCnt_q + 4'h1;
                    end
                    else if (sclFall && bitCnt_q == 4'h8)
                    begin
                        bitCnt_d = 4'h0;
                        if (st_q == ST_ADDR)
                        begin
                            // Foreign address: stay silent until the next start
                            if (shift_q[7:1] == myAddr)
                            begin
                                rw_d = shift_q[0];
                                st_d = ST_ACK;
                                drv_d = 1'b1;
                            end
                            else
                            begin
                                st_d = ST_IDLE;
                            end
                        end
                        else
                        begin
                            st_d = ST_ACK;
                            drv_d = 1'b1;
                            if (first_q)
                            begin
                                ptr_d = shift_q;
                                first_d = 1'b0;
                            end
                            else
                            begin
                                wr.en = 1'b1;
                                ptr_d = ptr_q + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK:
                begin
                    if (sclFall)
                    begin
                        if (rw_q)
                        begin
                            st_d = ST_READ;
                            shift_d = rdData;
                            ptr_d = ptr_q + 8'h01;
                            drv_d = ~rdData[7];
                        end
                        else
                        begin
                            st_d = ST_WRITE;
                            drv_d = 1'b0;
                        end
                    end
                end
                ST_READ:
                begin
                    if (sclFall)
                    begin
                        bitCnt_d = bitCnt_q + 4'h1;
                        if (bitCnt_q == 4'h7)
                        begin
                            st_d = ST_RACK;
                            bitCnt_d = 4'h0;
                            drv_d = 1'b0;
                        end
                        else
                        begin
                            shift_d = {shift_q[6:0], 1'b0};
                            drv_d = ~shift_q[6];
                        end
                    end
                end
                ST_RACK:
                begin
                    // Master not-acknowledge ends the read burst
                    if (sclRise && sdaF)
                    begin
                        st_d = ST_IDLE;
                    end
                    else if (sclFall)
                    begin
                        st_d = ST_READ;
                        shift_d = rdData;
                        ptr_d = ptr_q + 8'h01;
                        drv_d = ~rdData[7];
                    end
                end
                default:
                begin
                    st_d = ST_IDLE;
                    drv_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            drv_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            first_q <= first_d;
            drv_q <= drv_d;
        end
    end

    // Open-drain data line: only ever pulled low
    assign sdaOut = 1'b0;
    assign sdaOe = drv_q;

    // Register bank next values; the target itself is spared by soft resets
    // so the acknowledge of the triggering write still completes
    always_comb
    begin
        addrReg_d = addrReg_q;
        rstReg_d = rstReg_q;
        cfg_d = cfg_q;
        cfgB_d = cfgB_q;
        strapLatch_d = strapLatch_q;
        strapTaken_d = strapTaken_q;
        holdCnt_d = holdCnt_q;
        if (!strapTaken_q)
        begin
            // Strap caught once, first cycle after reset release
            strapLatch_d = addressStrap;
            strapTaken_d = 1'b1;
            addrReg_d = {addressStrap, RST_ADDR_SRC_SEL}; // [R01]
        end
        else if (wr.en)
        begin
            case (wr.addr)
                OFS_OWN_ADDR: addrReg_d = wr.data; // [R01] [R02]
                OFS_SOFT_RST: rstReg_d = wr.data; // [R03] [R05]
                OFS_OUT_CFG: cfg_d = wr.data; // [R12]
                OFS_GEN_CFG_B: cfgB_d = wr.data;
                default: addrReg_d = addrReg_q;
            endcase
        end
        else if (rstReg_q[FULL_RST_BIT] || rstReg_q[LOGIC_RST_BIT])
        begin
            // Hold the request a few cycles, then complete and clear
            if (holdCnt_q < 8'(RST_HOLD - 1))
            begin
                holdCnt_d = holdCnt_q + 8'h01;
            end
            else
            begin
                holdCnt_d = 8'h00;
                rstReg_d[LOGIC_RST_BIT] = 1'b0; // [R05] [R13]
                rstReg_d[FULL_RST_BIT] = 1'b0; // [R13]
                if (rstReg_q[FULL_RST_BIT])
                begin
                    addrReg_d = {strapLatch_q, RST_ADDR_SRC_SEL}; // [R04]
                    rstReg_d = RST_SOFT_RST; // [R03] [R06]
                    cfg_d = RST_OUT_CFG; // [R03]
                    cfgB_d = RST_GEN_CFG_B;
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            addrReg_q <= 8'h00;
            rstReg_q <= RST_SOFT_RST; // [R06]
            cfg_q <= RST_OUT_CFG; // [R07] [R12]
            cfgB_q <= RST_GEN_CFG_B;
            strapLatch_q <= 7'h00;
            strapTaken_q <= 1'b0;
            holdCnt_q <= 8'h00;
        end
        else
        begin
            addrReg_q <= addrReg_d;
            rstReg_q <= rstReg_d;
            cfg_q <= cfg_d;
            cfgB_q <= cfgB_d;
            strapLatch_q <= strapLatch_d;
            strapTaken_q <= strapTaken_d;
            holdCnt_q <= holdCnt_d;
        end
    end

    // Effective controls; without override both defaults are 1
    always_comb
    begin
        ctrl.outputEnable = cfg_q[OE_OVERRIDE_BIT] ? cfg_q[OE_VALUE_BIT] : 1'b1; // [R07] [R09]
        ctrl.sleepStateSel = cfg_q[OE_OVERRIDE_BIT] ? cfg_q[SLEEP_STATE_BIT] : 1'b1; // [R11] [R09]
        ctrl.oscClockToPclk = cfg_q[FALLBACK_CLK_BIT] & ~lockF; // [R10]
        ctrl.fullCoreReset = rstReg_q[FULL_RST_BIT]; // [R03]
        ctrl.logicReset = rstReg_q[FULL_RST_BIT] | rstReg_q[LOGIC_RST_BIT]; // [R05]
        ctrl.ownAddress = myAddr;
        ctrl.genCfgB = cfgB_q;
    end

endmodule

`default_nettype wire

// File: tb/dsrc_ctrl_regs_checker.sv
// Port checker for the control register bank
`timescale 1ns/1ps
`default_nettype none
module dsrc_ctrl_regs_checker #(
    parameter int RST_HOLD = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [6:0] addressStrap,
    input wire logic lockPin,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire dsrc_pkg::dsrc_ctrl_t ctrl
);
    import dsrc_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [3:0] hiCnt_q;
    logic [3:0] hiCnt_d;
    // Length of the current soft reset pulse; a stuck bit overruns it
    always_comb
    begin
        hiCnt_d = ctrl.logicReset ? hiCnt_q + 4'h1 : 4'h0;
    end
    always_ff @(posedge clock)
    begin
        hiCnt_q <= sys_rst ? 4'h0 : hiCnt_d;
    end
    property p_rst_out;
        $fell(sys_rst) |-> ctrl.outputEnable && ctrl.sleepStateSel && ctrl.genCfgB == 8'hf0;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs wrong after reset");
    property p_rst_pulse;
        $fell(sys_rst) |-> !ctrl.fullCoreReset && !ctrl.logicReset && !ctrl.oscClockToPclk;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset bits set after reset");
    property p_strap;
        $fell(sys_rst) |-> ##[1:3] ctrl.ownAddress == addressStrap;
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap address not taken");
    property p_full_logic;
        ctrl.fullCoreReset |-> ctrl.logicReset;
    endproperty
    a_full_logic: assert property (p_full_logic)
        else $error("full reset without core reset");
    property p_pulse_len;
        hiCnt_q <= 4'(RST_HOLD + 1);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("soft reset never clears");
    property p_osc_lock;
        lockPin [*8] |-> !ctrl.oscClockToPclk;
    endproperty
    a_osc_lock: assert property (p_osc_lock)
        else $error("oscillator out while locked");
    property p_full_addr;
        $fell(ctrl.fullCoreReset) |-> ##[0:3] ctrl.ownAddress == addressStrap;
    endproperty
    a_full_addr: assert property (p_full_addr)
        else $error("strap address not restored");
    property p_full_dflt;
        $fell(ctrl.fullCoreReset) |-> ##[0:3] ctrl.outputEnable && ctrl.genCfgB == 8'hf0;
    endproperty
    a_full_dflt: assert property (p_full_dflt)
        else $error("registers kept by full reset");
    property p_keep;
        ctrl.logicReset && !ctrl.fullCoreReset |=> $stable(ctrl.ownAddress);
    endproperty
    a_keep: assert property (p_keep)
        else $error("core reset changed address");
endmodule
bind dsrc_ctrl_regs dsrc_ctrl_regs_checker #(.RST_HOLD(RST_HOLD)) dsrc_ctrl_regs_checker_i (
    .clock(clock), .sys_rst(sys_rst), .addressStrap(addressStrap), .lockPin(lockPin),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .ctrl(ctrl));
`default_nettype wire

// File: tb/dsrc_i2c_host.sv
// Control bus host model that reads and writes the register bank
`timescale 1ns/1ps
`default_nettype none
module dsrc_i2c_host (
    input wire logic clock,
    input wire logic sdaWire,
    output logic scl,
    output logic sdaDrv
);
    // Lines released at time zero; pull-ups hold them high
    initial
    begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // Six clocks a quarter bit, well above the target's line filter
    task automatic q();
        repeat (6) @(posedge clock);
        #1;
    endtask
    // Line changes one quarter apart: data, clock, then the opposite pair
    task automatic seq(input logic d0, input logic c0, input logic d1, input logic c1);
        sdaDrv = d0;
        q();
        scl = c0;
        q();
        sdaDrv = d1;
        q();
        scl = c1;
        q();
    endtask
    // Eight bits MSB first, then a released ninth bit
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 8; i >= 0; i--)
        begin
            sdaDrv = (i == 0) ? 1'b1 : tx[i - 1];
            q();
            scl = 1'b1;
            q();
            if (i > 0)
                rx[i - 1] = sdaWire;
            ack = ~sdaWire;
            q();
            scl = 1'b0;
            q();
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
                      output logic ok);
        logic [7:0] rx;
        logic k0, k1, k2;
        seq(1'b1, 1'b1, 1'b0, 1'b0);
        xbyte({a, 1'b0}, rx, k0);
        xbyte(ofs, rx, k1);
        xbyte(d, rx, k2);
        seq(1'b0, 1'b1, 1'b1, 1'b1);
        ok = k0 & k1 & k2;
    endtask
    // Pointer write, repeated start, one byte read ended by a release
    task automatic rd(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] d,
                      output logic ok);
        logic [7:0] rx;
        logic k0, k1, k2, k3;
        seq(1'b1, 1'b1, 1'b0, 1'b0);
        xbyte({a, 1'b0}, rx, k0);
        xbyte(ofs, rx, k1);
        seq(1'b1, 1'b1, 1'b0, 1'b0);
        xbyte({a, 1'b1}, rx, k2);
        xbyte(8'hff, d, k3);
        seq(1'b0, 1'b1, 1'b1, 1'b1);
        ok = k0 & k1 & k2;
    endtask
endmodule
`default_nettype wire

// File: tb/deser_id_reset_output_cfg_test.sv
// Self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module deser_id_reset_output_cfg_test;
    import dsrc_pkg::*;
    typedef struct packed {
        logic [7:0] ofs;
        logic [7:0] val;
        logic lock;
        logic oe;
        logic ss;
        logic osc;
    } dsrc_row_t;
    localparam logic [6:0] STRAP = 7'h2c;
    localparam logic [6:0] ALT = 7'h51;
    logic clock = 1'b0;
    logic sysRst = 1'b1;
    logic lockPin = 1'b1;
    logic scl, sdaDrv, sdaOe, sdaOut, ok, sawFull, sawLogic;
    logic [7:0] rdv;
    wire logic sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
    dsrc_ctrl_t ctrl;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] rstVals [6] = '{{STRAP, 1'b0}, 8'h04, 8'h80, 8'hf0, 8'h00, 8'h00};
    dsrc_row_t rows [7] = '{'{8'h03, 8'h5a, 1, 1, 1, 0}, '{8'h02, 8'h00, 1, 1, 1, 0},
        '{8'h02, 8'h40, 1, 0, 0, 0}, '{8'h02, 8'hd0, 1, 1, 1, 0}, '{8'h02, 8'h2f, 0, 1, 1, 1},
        '{8'h02, 8'h20, 1, 1, 1, 0}, '{8'h02, 8'h6a, 0, 0, 0, 1}};
    dsrc_ctrl_regs #(.RST_HOLD(4)) dsrc_ctrl_regs_i (.clock(clock), .sys_rst(sysRst),
        .addressStrap(STRAP), .lockPin(lockPin), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .ctrl(ctrl));
    dsrc_i2c_host dsrc_i2c_host_i (.clock(clock), .sdaWire(sdaWire), .scl(scl),
        .sdaDrv(sdaDrv));
    always #50 clock = ~clock;
    // Cycle ceiling well above the roughly 30000 cycles the tests need
    always @(posedge clock)
    begin
        cycles++;
        if (ctrl.fullCoreReset)
            sawFull <= 1'b1;
        if (ctrl.logicReset)
            sawLogic <= 1'b1;
        if (cycles == 60000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic readBack(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] exp);
        dsrc_i2c_host_i.rd(a, ofs, rdv, ok);
        check("read ack", 8'h01, 8'(ok));
        check($sformatf("register %h", ofs), exp, rdv);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic pulseReset();
        sysRst = 1'b1;
        repeat (16) @(posedge clock);
        #1;
        sysRst = 1'b0;
        repeat (12) @(posedge clock);
        #1;
    endtask
    initial
    begin
        pulseReset();
        // Table rows: write, read back, then the derived controls
        foreach (rows[i])
        begin
            lockPin = rows[i].lock;
            dsrc_i2c_host_i.wr(STRAP, rows[i].ofs, rows[i].val, ok);
            readBack(STRAP, rows[i].ofs, rows[i].val);
            check("output enable", 8'(rows[i].oe), 8'(ctrl.outputEnable));
            check("sleep select", 8'(rows[i].ss), 8'(ctrl.sleepStateSel));
            check("osc to pclk", 8'(rows[i].osc), 8'(ctrl.oscClockToPclk));
            if (rows[i].ofs == 8'h03)
                check("general cfg b", rows[i].val, ctrl.genCfgB);
        end
        check("sda out level", 8'h00, 8'(sdaOut));
        $display("test table done");
        // Second reset in mid-run, then reset values and two unmapped offsets
        lockPin = 1'b1;
        pulseReset();
        foreach (rstVals[i])
            readBack(STRAP, 8'(i + (i / 5)), rstVals[i]);
        $display("test reset values done");
        // Programmed address replaces the strap one
        dsrc_i2c_host_i.wr(STRAP, 8'h00, {ALT, 1'b1}, ok);
        check("own address", {1'b0, ALT}, {1'b0, ctrl.ownAddress});
        readBack(ALT, 8'h00, {ALT, 1'b1});
        dsrc_i2c_host_i.rd(STRAP, 8'h00, rdv, ok);
        check("old address ack", 8'h00, 8'(ok));
        $display("test address source done");
        // Enable raised under override, then the register-keeping reset
        dsrc_i2c_host_i.wr(ALT, 8'h02, 8'h40, ok);
        dsrc_i2c_host_i.wr(ALT, 8'h02, 8'hc0, ok);
        sawFull = 1'b0;
        sawLogic = 1'b0;
        // Reserved bit 2 is written back as 1 so the register reads 04h afterwards
        dsrc_i2c_host_i.wr(ALT, 8'h01, 8'h05, ok);
        check("core reset seen", 8'h01, 8'(sawLogic));
        check("full reset seen", 8'h00, 8'(sawFull));
        readBack(ALT, 8'h01, 8'h04);
        readBack(ALT, 8'h02, 8'hc0);
        sawLogic = 1'b0;
        dsrc_i2c_host_i.wr(ALT, 8'h01, 8'h04, ok);
        check("zero write reset", 8'h00, 8'(sawLogic));
        $display("test core reset done");
        // Full reset returns every register, address from the strap
        dsrc_i2c_host_i.wr(ALT, 8'h01, 8'h02, ok);
        check("full reset seen", 8'h01, 8'(sawFull));
        readBack(STRAP, 8'h00, {STRAP, 1'b0});
        readBack(STRAP, 8'h02, 8'h80);
        readBack(STRAP, 8'h01, 8'h04);
        $display("test full reset done");
        conclude();
    end
endmodule
`default_nettype wire
